//--- rtl/ifd_map.vh
/*
 Field layout and opcode constants for the instruction field decoder.
 Assumes inclusion by the decoder files only.
*/
`ifndef IFD_MAP_VH
`define IFD_MAP_VH
`define IFD_BYTE_OP_HI 15
`define IFD_BYTE_OP_LO 10
`define IFD_DEST_BIT 9
`define IFD_BANK_BIT 8
`define IFD_FILE_HI 7
`define IFD_FILE_LO 0
`define IFD_NIB_HI 15
`define IFD_NIB_LO 12
`define IFD_BITPOS_HI 11
`define IFD_BITPOS_LO 9
`define IFD_ADDR12_HI 11
`define IFD_ADDR12_LO 0
`define IFD_OFS_HI 6
`define IFD_OFS_LO 0
`define IFD_FAST_BIT 0
`define IFD_SECOND_NIB 4'hf
`define IFD_MOVE_NIB 4'hc
`define IFD_BITSET_NIB 4'h8
`define IFD_BITCLR_NIB 4'h9
`define IFD_BITTGL_NIB 4'h7
`define IFD_CALL_HI 8'hec
`define IFD_CALL_FAST 8'hed
`define IFD_RET_WORD 15'h0009
`define IFD_RETFIE_WORD 15'h0008
`define IFD_TBL_HI 12'h000
`define IFD_TBL_LO_BASE 4'h8
`define IFD_IDX_SRC_HI 8'he8
`define IFD_IDX_DST_HI 9'h1d6
`define IFD_OSC_PER_CYCLE 2'h3
`define IFD_PTR_W 21
`define IFD_LATCH_W 8
`define IFD_ACCESS_BANK 4'h0
`endif

//--- rtl/ifd_phase.v
/*
 Phase counter splitting each instruction cycle into oscillator periods.
 Assumes sys_clk is the oscillator and en gates all state.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ifd_map.vh"
module ifd_phase (
    // Clock and reset
    input wire sys_clk,
    input wire rstn,
    input wire en,
    // Cycle boundary
    output reg cycle_end_q
);
    reg [1:0] phase_q;
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            phase_q <= 2'h0;
            cycle_end_q <= 1'b0;
        end else if (en) begin
            phase_q <= phase_q + 2'h1;
            cycle_end_q <= (phase_q == (`IFD_OSC_PER_CYCLE - 2'h1)); // see (RULE12)
        end
    end
endmodule
`default_nettype wire

//--- rtl/ifd_decoder.v
/*
 Operand field decoder for 16-bit instruction words.
 Assumes one word is offered per instruction cycle, taken when word_valid is
 high at the last oscillator period; downstream acts on one-cycle op pulses.
*/
// Overview of operation
// (RULE1) Fast bit picks shadow save or restore
// (RULE2) Program memory pointer is 21 bits wide
// (RULE3) Program memory data latch is 8 bits
// (RULE4) Indexed source and destination offsets are 7-bit
// (RULE5) Don't-care bits never change decode
// (RULE6) Byte format: opcode, d, a, file
// (RULE7) d selects working register or file
// (RULE8) a forces access bank or bank register
// (RULE9) Two-word move: source, then 1111 destination
// (RULE10) Bit format: opcode, bit, a, file
// (RULE11) Lone second word executes as no-operation
// (RULE12) Two-word ops take two four-period cycles
// (RULE13) Hold move source until second word
`timescale 1ns/10ps
`default_nettype none
`include "ifd_map.vh"
module ifd_decoder (
    // Clock and reset
    input wire sys_clk,
    input wire rstn,
    input wire clk_en,
    // Fetched word
    input wire [15:0] instr_word,
    input wire word_valid,
    // Bank and table context
    input wire [3:0] bank_select_register,
    input wire [20:0] program_memory_pointer_in,
    input wire [7:0] program_memory_data_in,
    // Byte and bit operands
    output reg op_valid_q,
    output reg [5:0] byte_opcode_q,
    output reg [3:0] bit_opcode_q,
    output reg to_working_register_q,
    output reg to_file_q,
    output reg [11:0] file_addr_q,
    output reg [2:0] bit_pos_q,
    output reg is_bit_op_q,
    // Two-word move
    output reg file_to_file_move_q,
    output reg [11:0] move_src_q,
    output reg [11:0] move_dst_q,
    output reg nop_q,
    output reg busy_q,
    // Fast call and return
    output reg shadow_save_q,
    output reg shadow_restore_q,
    // Indexed offsets
    output reg [6:0] source_index_offset_q,
    output reg [6:0] destination_index_offset_q,
    output reg index_valid_q,
    // Table path
    output reg [20:0] program_memory_pointer_q,
    output reg [7:0] program_memory_data_latch_q
);
    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT2 = 1'b1;

    wire cycle_end;
    wire take;
    wire [3:0] nib;
    wire [7:0] hi8;
    reg state_q;
    reg state_d;
    reg [11:0] src_hold_q;
    reg [6:0] zs_hold_q;
    reg idx_pending_q;

    ifd_phase u_phase (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .en(clk_en),
        .cycle_end_q(cycle_end)
    );

    assign take = clk_en & cycle_end & word_valid; // see (RULE12)
    assign nib = instr_word[`IFD_NIB_HI:`IFD_NIB_LO];
    assign hi8 = instr_word[15:8];

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (nib == `IFD_MOVE_NIB || hi8 == `IFD_IDX_SRC_HI) begin
                    state_d = ST_WAIT2; // see (RULE13)
                end
            end
            ST_WAIT2: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            src_hold_q <= 12'h000;
            zs_hold_q <= 7'h00;
            idx_pending_q <= 1'b0;
            op_valid_q <= 1'b0;
            byte_opcode_q <= 6'h00;
            bit_opcode_q <= 4'h0;
            to_working_register_q <= 1'b0;
            to_file_q <= 1'b0;
            file_addr_q <= 12'h000;
            bit_pos_q <= 3'h0;
            is_bit_op_q <= 1'b0;
            file_to_file_move_q <= 1'b0;
            move_src_q <= 12'h000;
            move_dst_q <= 12'h000;
            nop_q <= 1'b0;
            busy_q <= 1'b0;
            shadow_save_q <= 1'b0;
            shadow_restore_q <= 1'b0;
            source_index_offset_q <= 7'h00;
            destination_index_offset_q <= 7'h00;
            index_valid_q <= 1'b0;
            program_memory_pointer_q <= 21'h000000;
            program_memory_data_latch_q <= 8'h00;
        end else if (clk_en) begin
            op_valid_q <= 1'b0;
            file_to_file_move_q <= 1'b0;
            nop_q <= 1'b0;
            shadow_save_q <= 1'b0;
            shadow_restore_q <= 1'b0;
            index_valid_q <= 1'b0;
            if (take) begin
                state_q <= state_d;
                if (state_q == ST_WAIT2) begin
                    busy_q <= 1'b0;
                    if (nib == `IFD_SECOND_NIB) begin
                        if (idx_pending_q) begin
                            source_index_offset_q <= zs_hold_q; // see (RULE4)
                            destination_index_offset_q <= instr_word[`IFD_OFS_HI:`IFD_OFS_LO];
                            index_valid_q <= 1'b1;
                        end else begin
                            move_src_q <= src_hold_q; // see (RULE13)
                            move_dst_q <= instr_word[`IFD_ADDR12_HI:`IFD_ADDR12_LO]; // see (RULE9)
                            file_to_file_move_q <= 1'b1;
                        end
                    end else begin
                        nop_q <= 1'b1;
                    end
                end else if (nib == `IFD_MOVE_NIB) begin
                    src_hold_q <= instr_word[`IFD_ADDR12_HI:`IFD_ADDR12_LO]; // see (RULE9)
                    idx_pending_q <= 1'b0;
                    busy_q <= 1'b1; // see (RULE12)
                end else if (hi8 == `IFD_IDX_SRC_HI) begin
                    // Bit 7 is a don't-care in the first word
                    zs_hold_q <= instr_word[`IFD_OFS_HI:`IFD_OFS_LO]; // see (RULE5)
                    idx_pending_q <= 1'b1;
                    busy_q <= 1'b1;
                end else if (nib == `IFD_SECOND_NIB) begin
                    nop_q <= 1'b1; // see (RULE11)
                end else if (instr_word[15:1] == `IFD_RET_WORD ||
                             instr_word[15:1] == `IFD_RETFIE_WORD) begin
                    shadow_restore_q <= instr_word[`IFD_FAST_BIT]; // see (RULE1)
                    op_valid_q <= 1'b1;
                end else if (hi8 == `IFD_CALL_HI || hi8 == `IFD_CALL_FAST) begin
                    shadow_save_q <= hi8[`IFD_FAST_BIT]; // see (RULE1)
                    op_valid_q <= 1'b1;
                end else if (instr_word[15:4] == `IFD_TBL_HI &&
                             instr_word[3] == 1'b1) begin
                    program_memory_pointer_q <= program_memory_pointer_in; // see (RULE2)
                    program_memory_data_latch_q <= program_memory_data_in; // see (RULE3)
                    op_valid_q <= 1'b1;
                end else if (nib == `IFD_BITSET_NIB || nib == `IFD_BITCLR_NIB ||
                             nib == `IFD_BITTGL_NIB) begin
                    bit_opcode_q <= nib; // see (RULE10)
                    bit_pos_q <= instr_word[`IFD_BITPOS_HI:`IFD_BITPOS_LO];
                    file_addr_q <= {(instr_word[`IFD_BANK_BIT] ? bank_select_register
                        : `IFD_ACCESS_BANK), instr_word[`IFD_FILE_HI:`IFD_FILE_LO]}; // see (RULE8)
                    is_bit_op_q <= 1'b1;
                    to_working_register_q <= 1'b0;
                    to_file_q <= 1'b1;
                    op_valid_q <= 1'b1;
                end else begin
                    byte_opcode_q <= instr_word[`IFD_BYTE_OP_HI:`IFD_BYTE_OP_LO]; // see (RULE6)
                    to_working_register_q <= ~instr_word[`IFD_DEST_BIT]; // see (RULE7)
                    to_file_q <= instr_word[`IFD_DEST_BIT]; // see (RULE7)
                    file_addr_q <= {(instr_word[`IFD_BANK_BIT] ? bank_select_register
                        : `IFD_ACCESS_BANK), instr_word[`IFD_FILE_HI:`IFD_FILE_LO]}; // see (RULE8)
                    is_bit_op_q <= 1'b0;
                    op_valid_q <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/ifd_decoder_assertions.sv
/* Port assertions for the instruction decoder.
   Assumes binding to ifd_decoder. */
`timescale 1ns/10ps
`default_nettype none
module ifd_chk (
    // Clock and inputs
    input wire sys_clk,
    input wire rstn,
    input wire clk_en,
    input wire [15:0] instr_word,
    input wire word_valid,
    input wire [3:0] bank_select_register,
    // Outputs
    input wire op_valid_q,
    input wire [5:0] byte_opcode_q,
    input wire to_file_q,
    input wire [11:0] file_addr_q,
    input wire [2:0] bit_pos_q,
    input wire file_to_file_move_q,
    input wire [11:0] move_dst_q,
    input wire nop_q,
    input wire busy_q,
    input wire shadow_restore_q,
    input wire [6:0] destination_index_offset_q,
    input wire index_valid_q
);
    reg [1:0] ph_q;
    wire at_end = clk_en && word_valid && ph_q == 2'h3;
    wire take = at_end && !busy_q;
    wire [3:0] nib = instr_word[15:12];
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) ph_q <= 2'h0;
        else if (clk_en) ph_q <= ph_q + 2'h1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_move; take && nib == 4'hc ##1 busy_q; endsequence
    sequence s_idx; take && instr_word[15:8] == 8'he8; endsequence
    property p_byte; take && nib[3:1] == 3'h1 |=> op_valid_q &&
        byte_opcode_q == $past(instr_word[15:10]) && to_file_q == $past(instr_word[9]); endproperty
    property p_bank; take && nib[3:1] == 3'h1 |=> file_addr_q ==
        {$past(instr_word[8]) ? $past(bank_select_register) : 4'h0, $past(instr_word[7:0])};
    endproperty
    property p_bit; take && nib == 4'h8 |=> bit_pos_q == $past(instr_word[11:9]) && to_file_q;
    endproperty
    property p_move; s_move ##3 (at_end && nib == 4'hf) |=> file_to_file_move_q && !busy_q &&
        move_dst_q == $past(instr_word[11:0]); endproperty
    property p_lone; take && nib == 4'hf |=> nop_q && !file_to_file_move_q; endproperty
    property p_fast; take && instr_word == 16'h0013 |=> shadow_restore_q && op_valid_q; endproperty
    property p_idx; s_idx ##4 (at_end && nib == 4'hf) |=> index_valid_q &&
        destination_index_offset_q == $past(instr_word[6:0]); endproperty
    property p_quiet; clk_en && !at_end |=> !op_valid_q && !nop_q && !file_to_file_move_q &&
        !index_valid_q; endproperty
    a_byte: assert property (p_byte) else $error("byte fields");
    a_bank: assert property (p_bank) else $error("bank select");
    a_bit: assert property (p_bit) else $error("bit fields");
    a_move: assert property (p_move) else $error("move pair");
    a_lone: assert property (p_lone) else $error("lone word");
    a_fast: assert property (p_fast) else $error("fast return");
    a_idx: assert property (p_idx) else $error("index pair");
    a_quiet: assert property (p_quiet) else $error("stray pulse");
endmodule
bind ifd_decoder ifd_chk chk_u (.*);
`default_nettype wire

//--- tb/ifd_fetch_model.sv
/* Fetch unit model: one queued word per instruction cycle.
   Assumes clk_en high and the bench pushing words. */
`timescale 1ns/10ps
`default_nettype none
module ifd_fetch_model (
    // Clock and control
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // Fetched word
    output logic [15:0] instr_word,
    output logic word_valid
);
    logic [1:0] ph_q = 2'h0;
    logic [15:0] prog_q[$];
    initial word_valid = 1'b0;
    initial instr_word = 16'h0000;
    task automatic push(input logic [15:0] w);
        prog_q.push_back(w);
    endtask
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) ph_q <= 2'h0;
        else if (clk_en) ph_q <= ph_q + 2'h1;
    end
    // Word leaves the queue when taken
    always @(posedge sys_clk) begin
        if (rstn && clk_en && word_valid && ph_q == 2'h3) void'(prog_q.pop_front());
    end
    // One word per cycle, otherwise a changing pattern
    always @(negedge sys_clk) begin
        if (ph_q == 2'h0 && prog_q.size() != 0) begin
            instr_word <= prog_q[0];
            word_valid <= 1'b1;
        end else if (ph_q == 2'h0 || !word_valid) begin
            instr_word <= ~instr_word;
            word_valid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- tb/instruction_field_decoder_tb_top.sv
/* Self-checking bench for the instruction decoder.
   Assumes the fetch model and bound checker. */
`timescale 1ns/10ps
`default_nettype none
module instruction_field_decoder_tb_top;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    logic [3:0] bank_select_register = 4'h0;
    logic [20:0] program_memory_pointer_in = 21'h1abcde;
    logic [7:0] program_memory_data_in = 8'h5c;
    logic [15:0] instr_word;
    logic word_valid, op_valid_q, to_working_register_q, to_file_q, is_bit_op_q, nop_q, busy_q;
    logic file_to_file_move_q, shadow_save_q, shadow_restore_q, index_valid_q;
    logic [5:0] byte_opcode_q;
    logic [3:0] bit_opcode_q;
    logic [11:0] file_addr_q, move_src_q, move_dst_q;
    logic [2:0] bit_pos_q;
    logic [6:0] source_index_offset_q, destination_index_offset_q;
    logic [20:0] program_memory_pointer_q;
    logic [7:0] program_memory_data_latch_q;
    int bad_count = 0;
    int n_tests = 0;
    ifd_fetch_model fetch_u (.*);
    ifd_decoder dut_u (.*);
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Queue words, wait until taken, stop in the answer cycle
    task automatic feed(input logic [15:0] a, input logic [15:0] b, input bit two);
        int n;
        fetch_u.push(a);
        if (two) fetch_u.push(b);
        for (n = 0; n < 40 && (n == 0 || fetch_u.prog_q.size() != 0); n++) @(negedge sys_clk);
        chk(n < 40, "fetch timeout");
        if (n >= 40) conclude();
    endtask
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (12) @(negedge sys_clk);
        chk(op_valid_q === 1'b0 && busy_q === 1'b0 && file_addr_q === 12'h000, "reset");
        rstn = 1'b1;
        for (int i = 0; i < 4; i++) begin
            bank_select_register = 4'h5 + 4'(i);
            feed({6'h09, i[1], i[0], 8'h5a}, 16'h0000, 1'b0);
            chk(byte_opcode_q === 6'h09 && op_valid_q === 1'b1, "byte opcode");
            chk(to_file_q === i[1] && to_working_register_q === !i[1], "dest");
            chk(file_addr_q === {i[0] ? 4'h5 + 4'(i) : 4'h0, 8'h5a}, "bank");
        end
        for (int i = 0; i < 8; i++) begin
            feed({4'h7 + 4'(i % 3), i[2:0], 1'b0, 8'h33}, 16'h0000, 1'b0);
            chk(bit_opcode_q === 4'h7 + 4'(i % 3) && bit_pos_q === i[2:0], "bit op");
            chk(is_bit_op_q === 1'b1 && file_addr_q === 12'h033, "bit file");
        end
        feed(16'hc123, 16'hf456, 1'b1);
        chk(file_to_file_move_q === 1'b1 && move_src_q === 12'h123, "move src");
        chk(move_dst_q === 12'h456 && busy_q === 1'b0, "move dst");
        feed(16'hf789, 16'h0000, 1'b0);
        chk(nop_q === 1'b1 && file_to_file_move_q === 1'b0, "lone word");
        feed(16'hcabc, 16'h2abc, 1'b1);
        chk(nop_q === 1'b1 && file_to_file_move_q === 1'b0, "broken pair");
        feed(16'h0013, 16'h0000, 1'b0);
        chk(shadow_restore_q === 1'b1 && shadow_save_q === 1'b0, "fast ret");
        feed(16'h0012, 16'h0000, 1'b0);
        chk(shadow_restore_q === 1'b0 && op_valid_q === 1'b1, "plain ret");
        feed(16'hed12, 16'h0000, 1'b0);
        chk(shadow_save_q === 1'b1 && op_valid_q === 1'b1, "fast call");
        feed(16'hec12, 16'h0000, 1'b0);
        chk(shadow_save_q === 1'b0 && op_valid_q === 1'b1, "plain call");
        feed(16'h0009, 16'h0000, 1'b0);
        chk(program_memory_pointer_q === 21'h1abcde, "pointer");
        chk(program_memory_data_latch_q === 8'h5c, "latch");
        feed(16'he8ff, 16'hf02a, 1'b1);
        chk(source_index_offset_q === 7'h7f && index_valid_q === 1'b1, "src ofs");
        chk(destination_index_offset_q === 7'h2a, "dst ofs");
        conclude();
    end
endmodule
`default_nettype wire
